//--- common/dpm_pkg.sv
// Purpose: shared types and constants of the channel power meter
// Assumes: 18-bit signed I/Q samples from the final channel filter
// Notes:   all counts are in samples, not clock cycles
package dpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int SMP_W = 18;   // I and Q sample width
  localparam int SQ_W  = 36;   // width of I*I + Q*Q
  localparam int ACC_W = 55;   // accumulator and result width
  localparam int CNT_W = 18;   // integration and interval counters
  localparam int DLY_W = 9;    // sync delay counter
  localparam int N_SYNC_PINS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // timing counts
  localparam logic [DLY_W-1:0] DLY_FIXED = 9'h003;   // 3 chips after sync
  localparam logic [9:0]       IVL_UNIT_M1 = 10'h3ff; // 1024-sample unit - 1
  localparam logic [1:0]       INT_UNIT_LSB = 2'h0;   // x4 samples

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [ACC_W-1:0] ACC_RST = 55'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 18'h0;
  localparam logic [DLY_W-1:0] DLY_RST = 9'h0;

  ////////////////////////////////////////////////////////////////////////////
  // sync source selection codes
  localparam logic [2:0] SSEL_PIN0 = 3'h0;
  localparam logic [2:0] SSEL_PIN1 = 3'h1;
  localparam logic [2:0] SSEL_PIN2 = 3'h2;
  localparam logic [2:0] SSEL_PIN3 = 3'h3;
  localparam logic [2:0] SSEL_SOFT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // measurement states, one-hot
  typedef enum logic [3:0] {
    DPM_IDLE  = 4'b0001,
    DPM_DELAY = 4'b0010,
    DPM_INTEG = 4'b0100,
    DPM_HOLD  = 4'b1000
  } dpm_state_t;

  // filtered sample, path 0 = signal (A), 1 = diversity (B)
  typedef struct packed {
    logic                    valid;
    logic                    path;
    logic signed [SMP_W-1:0] i;
    logic signed [SMP_W-1:0] q;
  } dpm_sample_t;

  // squared and summed sample
  typedef struct packed {
    logic            valid;
    logic            path;
    logic [SQ_W-1:0] sum;
  } dpm_sq_t;

  // static configuration bits
  typedef struct packed {
    logic        cdma_mode;
    logic [15:0] sqr_sum;
    logic [7:0]  sync_delay;
    logic [7:0]  interval;
    logic [2:0]  ssel;
    logic        sync_disable;
  } dpm_cfg_t;

endpackage

//--- hw/dpm_sqsum.sv
// Purpose: square I and Q and add the squares, one register stage
// Assumes: samples arrive on mclk_i with a valid flag
// Notes:   sum is unsigned and never overflows 36 bits
`timescale 1ns/1ps
module dpm_sqsum (
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            arst_n_i,
  // sample in
  input  wire dpm_pkg::dpm_sample_t smp_i,
  // squared sum out
  output dpm_pkg::dpm_sq_t      sq_o
);
  import dpm_pkg::*;

  logic signed [SQ_W-1:0] ii;
  logic signed [SQ_W-1:0] qq;
  dpm_sq_t                sq_d;
  dpm_sq_t                sq_q;

  ////////////////////////////////////////////////////////////////////////////
  // squares and their sum
  always_comb begin
    ii         = smp_i.i * smp_i.i;
    qq         = smp_i.q * smp_i.q;
    sq_d.valid = smp_i.valid;
    sq_d.path  = smp_i.path;
    sq_d.sum   = SQ_W'($unsigned(ii) + $unsigned(qq));
  end

  // pipeline register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sq_q <= '0;
    end else begin
      sq_q <= sq_d;
    end
  end

  assign sq_o = sq_q;

endmodule

//--- hw/dpm_meter.sv
// Purpose: per-channel power meter, sync-timed integration of I^2+Q^2
// Assumes: in CDMA mode each sample is an A beat followed by a B beat
// Notes:   sync pins are asynchronous and pass two flip-flops
// Contract
// - square 18-bit I and Q, add, accumulate during integration.
// - 16-bit integration setting, times four, is the end count of an 18-bit integration counter.
// - interval timer counts 1024-sample units, 1 to 256 units.
// - measurement starts on sync; integration after 3 chips plus delay.
// - 8-bit sync delay gives 1 to 256 samples offset.
// - at integration end copy 55-bit accumulator and pulse interrupt.
// - interval runs on after integration; both counters restart together.
// - each completion overwrites held result and pulses fresh interrupt.
// - any sync clears every meter counter immediately.
// - CDMA gives separate signal and diversity results; UMTS one.
// - result sums I^2+Q^2 over four times count plus one samples.
// - integration setting is in units of four samples.
// - interval setting unit conflicts; 1024 samples used here.
// - disable bit blocks sync to this channel only.
`timescale 1ns/1ps
module dpm_meter (
  // clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      arst_n_i,
  // filtered sample stream
  input  wire dpm_pkg::dpm_sample_t      smp_i,
  // sync sources
  input  wire logic [3:0]                sync_pin_i,
  input  wire logic                      sync_soft_i,
  // configuration
  input  wire dpm_pkg::dpm_cfg_t         cfg_i,
  // results
  output logic [dpm_pkg::ACC_W-1:0]      result_a_o,
  output logic [dpm_pkg::ACC_W-1:0]      result_b_o,
  output logic                           ready_irq_o,
  output logic                           busy_o
);
  import dpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  dpm_sq_t                  sq;
  logic [N_SYNC_PINS-1:0]   ss1_q;
  logic [N_SYNC_PINS-1:0]   ss2_q;
  logic [N_SYNC_PINS-1:0]   ss3_q;
  logic [N_SYNC_PINS-1:0]   pin_rise;
  logic                     sync_sel;
  logic                     sync_evt;
  dpm_state_t               state_d;
  dpm_state_t               state_q;
  logic [DLY_W-1:0]         dly_cnt_d;
  logic [DLY_W-1:0]         dly_cnt_q;
  logic [CNT_W-1:0]         int_cnt_d;
  logic [CNT_W-1:0]         int_cnt_q;
  logic [CNT_W-1:0]         ivl_cnt_d;
  logic [CNT_W-1:0]         ivl_cnt_q;
  logic [ACC_W-1:0]         acc_a_d;
  logic [ACC_W-1:0]         acc_a_q;
  logic [ACC_W-1:0]         acc_b_d;
  logic [ACC_W-1:0]         acc_b_q;
  logic [ACC_W-1:0]         res_a_d;
  logic [ACC_W-1:0]         res_a_q;
  logic [ACC_W-1:0]         res_b_d;
  logic [ACC_W-1:0]         res_b_q;
  logic                     irq_d;
  logic                     irq_q;
  logic                     tick;
  logic                     en_a;
  logic                     en_b;
  logic [ACC_W-1:0]         sum_a;
  logic [ACC_W-1:0]         sum_b;
  logic [DLY_W-1:0]         dly_end;
  logic [CNT_W-1:0]         int_end;
  logic [CNT_W-1:0]         ivl_end;
  logic                     int_done;
  logic                     ivl_done;

  ////////////////////////////////////////////////////////////////////////////
  // squarer stage
  dpm_sqsum u_sqsum (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .smp_i    (smp_i),
    .sq_o     (sq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sync pin synchronisers and edge history
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ss1_q <= '0;
      ss2_q <= '0;
      ss3_q <= '0;
    end else begin
      ss1_q <= sync_pin_i;
      ss2_q <= ss1_q;
      ss3_q <= ss2_q;
    end
  end

  // rising edge per pin, second and third stages only
  generate
    for (genvar g = 0; g < N_SYNC_PINS; g++) begin : g_rise
      assign pin_rise[g] = ss2_q[g] & ~ss3_q[g];
    end
  endgenerate

  // source selection and per-channel gate
  always_comb begin
    case (cfg_i.ssel)
      SSEL_PIN0: sync_sel = pin_rise[0];
      SSEL_PIN1: sync_sel = pin_rise[1];
      SSEL_PIN2: sync_sel = pin_rise[2];
      SSEL_PIN3: sync_sel = pin_rise[3];
      SSEL_SOFT: sync_sel = sync_soft_i;
      default:   sync_sel = 1'b0;
    endcase
    sync_evt = sync_sel & ~cfg_i.sync_disable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample tick and accumulate enables
  always_comb begin
    tick     = sq.valid & (cfg_i.cdma_mode ? sq.path : 1'b1);
    en_a     = sq.valid & (~cfg_i.cdma_mode | ~sq.path);
    en_b     = sq.valid & cfg_i.cdma_mode & sq.path;
    sum_a    = acc_a_q + ACC_W'(sq.sum);
    sum_b    = acc_b_q + ACC_W'(sq.sum);
    dly_end  = {1'b0, cfg_i.sync_delay} + DLY_FIXED;
    int_end  = {cfg_i.sqr_sum, INT_UNIT_LSB};
    ivl_end  = {cfg_i.interval, IVL_UNIT_M1};
    int_done = tick & (int_cnt_q == int_end);
    ivl_done = tick & (ivl_cnt_q == ivl_end);
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequencer next state
  always_comb begin
    state_d   = state_q;
    dly_cnt_d = dly_cnt_q;
    int_cnt_d = int_cnt_q;
    ivl_cnt_d = ivl_cnt_q;
    acc_a_d   = acc_a_q;
    acc_b_d   = acc_b_q;
    res_a_d   = res_a_q;
    res_b_d   = res_b_q;
    irq_d     = 1'b0;
    if (sync_evt) begin
      // sync restarts all counters and accumulators from any state; results are kept
      state_d   = DPM_DELAY;
      dly_cnt_d = DLY_RST;
      int_cnt_d = CNT_RST;
      ivl_cnt_d = CNT_RST;
      acc_a_d   = ACC_RST;
      acc_b_d   = ACC_RST;
    end else begin
      case (state_q)
        DPM_IDLE: begin
          state_d = DPM_IDLE;
        end
        DPM_DELAY: begin
          if (tick) begin
            if (dly_cnt_q == dly_end) begin
              state_d   = DPM_INTEG;
              dly_cnt_d = DLY_RST;
            end else begin
              dly_cnt_d = dly_cnt_q + 9'h001;
            end
          end
        end
        DPM_INTEG, DPM_HOLD: begin
          if (state_q == DPM_INTEG) begin
            if (en_a) begin
              acc_a_d = sum_a;
            end
            if (en_b) begin
              acc_b_d = sum_b;
            end
            if (int_done) begin
              // latch includes the final sample of the window
              res_a_d = en_a ? sum_a : acc_a_q;
              res_b_d = en_b ? sum_b : acc_b_q;
              irq_d   = 1'b1;
              state_d = DPM_HOLD;
            end else if (tick) begin
              int_cnt_d = int_cnt_q + 18'h00001;
            end
          end
          if (ivl_done) begin
            // interval wrap restarts both counters together
            state_d   = DPM_INTEG;
            int_cnt_d = CNT_RST;
            ivl_cnt_d = CNT_RST;
            acc_a_d   = ACC_RST;
            acc_b_d   = ACC_RST;
          end else if (tick) begin
            ivl_cnt_d = ivl_cnt_q + 18'h00001;
          end
        end
        default: begin
          state_d = DPM_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q   <= DPM_IDLE;
      dly_cnt_q <= DLY_RST;
      int_cnt_q <= CNT_RST;
      ivl_cnt_q <= CNT_RST;
      acc_a_q   <= ACC_RST;
      acc_b_q   <= ACC_RST;
      res_a_q   <= ACC_RST;
      res_b_q   <= ACC_RST;
      irq_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      dly_cnt_q <= dly_cnt_d;
      int_cnt_q <= int_cnt_d;
      ivl_cnt_q <= ivl_cnt_d;
      acc_a_q   <= acc_a_d;
      acc_b_q   <= acc_b_d;
      res_a_q   <= res_a_d;
      res_b_q   <= res_b_d;
      irq_q     <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign result_a_o  = res_a_q;
  assign result_b_o  = res_b_q;
  assign ready_irq_o = irq_q;
  assign busy_o      = (state_q == DPM_INTEG);

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_irq_on_done:
    assert property ((state_q == DPM_INTEG) && int_done && !sync_evt
                     |=> ready_irq_o && (state_q != DPM_DELAY))
      else $error("no interrupt after integration end");

  a_result_latch:
    assert property ((state_q == DPM_INTEG) && int_done && !sync_evt
                     |=> result_a_o == $past(acc_a_q)
                         + ($past(en_a) ? ACC_W'($past(sq.sum)) : ACC_RST)
                         && result_b_o == $past(acc_b_q)
                         + ($past(en_b) ? ACC_W'($past(sq.sum)) : ACC_RST))
      else $error("result not latched at integration end");

  a_irq_cause:
    assert property (ready_irq_o |-> $past(state_q) == DPM_INTEG
                     && $past(int_done))
      else $error("interrupt without completed integration");

  a_sync_clears:
    assert property (sync_evt |=> state_q == DPM_DELAY
                     && int_cnt_q == CNT_RST && ivl_cnt_q == CNT_RST
                     && dly_cnt_q == DLY_RST && acc_a_q == ACC_RST)
      else $error("sync did not clear counters");

  a_disable_blocks:
    assert property (cfg_i.sync_disable && (state_q == DPM_IDLE)
                     |=> state_q == DPM_IDLE)
      else $error("sync passed while disabled");

  a_hold_invalid:
    assert property (!sq.valid && !sync_evt
                     |=> $stable(acc_a_q) && $stable(acc_b_q)
                         && $stable(int_cnt_q) && $stable(ivl_cnt_q))
      else $error("meter advanced without a valid sample");

  a_acc_adds:
    assert property ((state_q == DPM_INTEG) && en_a && !sync_evt
                     && !ivl_done
                     |=> acc_a_q == $past(acc_a_q) + ACC_W'($past(sq.sum)))
      else $error("accumulator did not add the squared sum");

  a_ivl_restart:
    assert property ((state_q != DPM_IDLE) && (state_q != DPM_DELAY)
                     && ivl_done && !sync_evt
                     |=> state_q == DPM_INTEG && int_cnt_q == CNT_RST
                         && ivl_cnt_q == CNT_RST)
      else $error("interval end did not restart both counters");

  a_delay_start:
    assert property ((state_q == DPM_DELAY) && tick && !sync_evt
                     && (dly_cnt_q == dly_end)
                     |=> state_q == DPM_INTEG && acc_a_q == ACC_RST)
      else $error("integration did not start after sync delay");

  a_umts_one_path:
    assert property (!cfg_i.cdma_mode && (state_q == DPM_INTEG)
                     && !sync_evt && !ivl_done |=> $stable(acc_b_q))
      else $error("diversity path accumulated in single-path mode");

  a_int_bound:
    assert property ((state_q == DPM_INTEG) && $stable(cfg_i)
                     |-> int_cnt_q <= int_end)
      else $error("integration counter passed its end");

endmodule

//--- dv/dpm_src_model.sv
// Purpose: far-side model, final filter sample stream for the meter
// Assumes: restart_i is the same-cycle soft sync seen by the meter
// Notes:   sample index j restarts at 1 after each restart pulse
`timescale 1ns/1ps
module dpm_src_model
  import dpm_pkg::*;
(
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            arst_n_i,
  // control from the bench
  input  wire logic            restart_i,
  input  wire logic            cdma_i,
  input  wire logic            gap_i,
  // sample stream
  output dpm_pkg::dpm_sample_t smp_o
);
  logic [17:0] cnt_q, cnt_d;
  logic        ph_q, ph_d, tg_q, tg_d, vld;

  // beat i = j, q = 1 on A, 3 on B; idle beats carry inverted junk
  always_comb begin
    vld = arst_n_i && !restart_i && !(gap_i && tg_q);
    smp_o.valid = vld;
    smp_o.path = ph_q;
    smp_o.i = vld ? cnt_q : ~cnt_q;
    smp_o.q = vld ? (ph_q ? 18'h00003 : 18'h00001) : ~cnt_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    tg_d = !tg_q;
    if (restart_i) begin
      cnt_d = 18'h00001;
      ph_d = 1'b0;
    end else if (vld) begin
      ph_d = cdma_i && !ph_q;
      if (!cdma_i || ph_q) cnt_d = cnt_q + 18'h00001;
    end
  end

  // state registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 18'h00001;
      ph_q <= 1'b0;
      tg_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      tg_q <= tg_d;
    end
  end
endmodule

//--- dv/dpm_meter_tb.sv
// Purpose: self-checking bench of the channel power meter
// Assumes: ramp stream from the source model, soft sync by default
// Notes:   expected powers are summed here from the ramp indices
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; \
  if ((gt) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module dpm_meter_tb;
  import dpm_pkg::*;
  logic              mclk_i, arst_n_i, sync_soft, gap, irq, busy;
  logic [3:0]        pins;
  dpm_cfg_t          cfg;
  dpm_sample_t       smp;
  logic [ACC_W-1:0]  res_a, res_b;
  int                bad_count, num_checks;

  dpm_src_model src (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .restart_i(sync_soft), .cdma_i(cfg.cdma_mode), .gap_i(gap),
    .smp_o(smp));
  dpm_meter dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .smp_i(smp),
    .sync_pin_i(pins), .sync_soft_i(sync_soft), .cfg_i(cfg),
    .result_a_o(res_a), .result_b_o(res_b), .ready_irq_o(irq),
    .busy_o(busy));

  // 25 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic do_reset();
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    #1;
  endtask

  task automatic pulse_soft();
    @(posedge mclk_i);
    sync_soft <= 1'b1;
    @(posedge mclk_i);
    sync_soft <= 1'b0;
  endtask

  task automatic pulse_pins(logic [3:0] m);
    @(posedge mclk_i);
    pins <= m;
    repeat (4) @(posedge mclk_i);
    pins <= 4'h0;
  endtask

  // bounded wait for the ready pulse
  task automatic wait_irq();
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while (irq !== 1'b1 && k < 40000);
    if (irq !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  // sum of j*j + qq over c samples from index f
  function automatic logic [ACC_W-1:0] esum(int f, int c, int qq);
    longint s;
    s = 0;
    for (int j = f; j < f + c; j++) s += longint'(j) * j + qq;
    return ACC_W'(s);
  endfunction

  // one sync, optional resync, then two results across an interval
  task automatic t_meas(string nm, logic cm, logic gp, int d, int n,
                        int iv, int mid);
    int f;
    @(posedge mclk_i);
    cfg.cdma_mode <= cm;
    cfg.sync_delay <= 8'(d);
    cfg.sqr_sum <= 16'(n);
    cfg.interval <= 8'(iv);
    cfg.ssel <= SSEL_SOFT;
    gap <= gp;
    pulse_soft();
    if (mid > 0) begin
      cyc(mid);
      pulse_soft();
    end
    f = d + 5;
    for (int r = 0; r < 2; r++) begin
      wait_irq();
      `CHK("result_a", esum(f, 4 * n + 1, 1), res_a)
      if (cm) `CHK("result_b", esum(f, 4 * n + 1, 9), res_b)
      `CHK("busy at done", 1'b0, busy)
      cyc(1);
      `CHK("irq width", 1'b0, irq)
      f = f + (iv + 1) * 1024;
    end
    $display("test %s done", nm);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] m;
    arst_n_i = 1'b0;
    sync_soft = 1'b0;
    pins = 4'h0;
    gap = 1'b0;
    cfg = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    cyc(1);
    `CHK("reset result", 55'h0, res_a)
    `CHK("reset irq", 1'b0, irq)
    // interval kept above integration count
    t_meas("basic", 1'b0, 1'b0, 0, 0, 0, 0);
    t_meas("gap", 1'b0, 1'b1, 255, 3, 0, 0);
    t_meas("cdma", 1'b1, 1'b0, 7, 300, 1, 0);
    t_meas("resync", 1'b0, 1'b0, 2, 100, 0, 100);
    @(posedge mclk_i);
    cfg.cdma_mode <= 1'b0;
    cfg.sqr_sum <= 16'h0014;
    cfg.sync_delay <= 8'h00;
    for (int s = 0; s < 8; s++) begin
      do_reset();
      @(posedge mclk_i);
      cfg.ssel <= 3'(s);
      m = 4'(1 << s);
      pulse_pins(s < 4 ? ~m : 4'hf);
      cyc(40);
      `CHK("busy foreign source", 1'b0, busy)
      if (s < 4) pulse_pins(m);
      else pulse_soft();
      cyc(40);
      `CHK("busy own source", (s <= 4) ? 1'b1 : 1'b0, busy)
    end
    $display("test source select done");
    do_reset();
    @(posedge mclk_i);
    cfg.ssel <= SSEL_SOFT;
    cfg.sync_disable <= 1'b1;
    pulse_soft();
    cyc(40);
    `CHK("busy when disabled", 1'b0, busy)
    $display("test disable done");
    report_and_stop();
  end
endmodule
